//--- gpsp_pkg.sv
package gpsp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PORT_D_DATA      = 8'h08;
  localparam logic [7:0] IDX_PORT_D_DIRECTION = 8'h88;
  localparam logic [7:0] IDX_PORT_E_DIRSC     = 8'h89;
  localparam logic [7:0] IDX_CONTROL_PORT     = 8'h09;
  localparam logic [7:0] IDX_ANALOG_CONFIG    = 8'h9f;
  localparam logic [7:0] IDX_IRQ_STATUS       = 8'h0c;
  localparam logic [7:0] IDX_IRQ_MASK         = 8'h8c;
  // control register fields
  localparam int BIT_INPUT_FULL   = 7;
  localparam int BIT_OUTPUT_FULL  = 6;
  localparam int BIT_OVERRUN      = 5;
  localparam int BIT_SLAVE_SELECT = 4;
  localparam int BIT_CTL_UNUSED   = 3;
  // reset values
  localparam logic [7:0] RST_PORT_D_DIRECTION = 8'hff;
  localparam logic [7:0] RST_PORT_E_DIRSC     = 8'h07;
  localparam logic [2:0] RST_ANALOG_CONFIG    = 3'h7;
  localparam logic [7:0] RST_PORT_D_DATA      = 8'h00;
  // interrupt status bits
  localparam int IRQ_WRITE_IN  = 0;
  localparam int IRQ_READ_OUT  = 1;
  localparam int IRQ_OVERRUN   = 2;
  localparam int IRQ_BITS      = 3;
  typedef enum logic [1:0] {
    STROBE_IDLE   = 2'b00,
    STROBE_READ   = 2'b01,
    STROBE_WRITE  = 2'b10
  } gpsp_strobe_t;
endpackage : gpsp_pkg

//--- gpsp_strobe.sv
`timescale 1ns/1ns
`default_nettype none
// turns the active-low slave strobes into one-cycle end-of-access pulses
module gpsp_strobe
  import gpsp_pkg::*;
(
  // clock and reset
  input  wire logic core_clk,
  input  wire logic reset,
  // strobes
  input  wire logic enable,
  input  wire logic selectN,
  input  wire logic readN,
  input  wire logic writeN,
  // events
  output logic      readActive,
  output logic      readDone,
  output logic      writeDone
);
  import gpsp_pkg::*;
  gpsp_strobe_t state;
  gpsp_strobe_t next_state;
  always_comb begin
    next_state = state;
    if (!enable) begin
      next_state = STROBE_IDLE;
    end else begin
      unique case (state)
        STROBE_IDLE: begin
          if (!selectN && !writeN) next_state = STROBE_WRITE;
          else if (!selectN && !readN) next_state = STROBE_READ;
        end
        STROBE_READ: if (readN || selectN) next_state = STROBE_IDLE;
        STROBE_WRITE: if (writeN || selectN) next_state = STROBE_IDLE;
        default: next_state = STROBE_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) state <= STROBE_IDLE;
    else state <= next_state;
  end
  // events complete at the strobe's rising edge, as on a real bus
  assign readActive = (state == STROBE_READ) && !readN && !selectN;
  assign readDone   = (state == STROBE_READ) && (next_state == STROBE_IDLE);
  assign writeDone  = (state == STROBE_WRITE) && (next_state == STROBE_IDLE);
endmodule : gpsp_strobe
`default_nettype wire

//--- gpsp_port.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - each of the eight data pins has its own direction bit.
// - setting bit 4 of the control register turns the data port into a byte-wide slave port.
// - each of the three control pins has its own direction bit.
// - in slave mode the three control pins act as read, write and select inputs.
// - a control pin configured as analog reads back as zero.
// - control direction bits still drive the pins while they are analog.
// - after reset the control pins are analog and read as zero.
// - the data direction register resets to all ones and the data latch is not reset.
// - the control register resets to 0000 -111 with two read-only flags and bit 3 zero.
// - output-full is set while a word written in slave mode has not been read externally.
// - except for the data pins in slave mode, direction one makes a pin a high-impedance input, zero drives the latch.
// - overrun sets when an external write lands on an unread word and stays until cleared.
// - a selected external read puts the data latch on the data pins.
// - a selected external write latches the data pins into the data register.
module gpsp_port
  import gpsp_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // data port pins
  input  wire logic [7:0]  portDIn,
  output logic      [7:0]  portDOut,
  output logic      [7:0]  portDOeN,
  // control port pins
  input  wire logic [2:0]  controlPortIn,
  output logic      [2:0]  controlPortOut,
  output logic      [2:0]  controlPortOeN,
  // interrupt
  output logic             irq
);
  import gpsp_pkg::*;

  logic [7:0] portDData, next_portDData;
  logic [7:0] portDDirection, next_portDDirection;
  logic [2:0] portEDirection, next_portEDirection;
  logic [2:0] portELatch, next_portELatch;
  logic [2:0] analogConfig, next_analogConfig;
  logic       slaveSelect, next_slaveSelect;
  logic       inputFull, next_inputFull;
  logic       outputFull, next_outputFull;
  logic       overrun, next_overrun;
  logic [IRQ_BITS-1:0] irqStatus, next_irqStatus;
  logic [IRQ_BITS-1:0] irqMask, next_irqMask;
  logic        ack, next_ack;
  logic [31:0] rdData, next_rdData;
  logic readActive, readDone, writeDone;

  function automatic logic hit(input logic [7:0] idx);
    hit = (wb_adr_i == {idx, 2'b00});
  endfunction : hit

  wire logic req    = wb_cyc_i && wb_stb_i && !ack;
  wire logic wrLow  = req && wb_we_i && wb_sel_i[0];
  wire logic rdReq  = req && !wb_we_i;
  // analog pins read as zero
  wire logic [2:0] controlRead = controlPortIn & ~analogConfig;

  gpsp_strobe u_strobe (
    .core_clk   (core_clk),
    .reset      (reset),
    .enable     (slaveSelect),
    .selectN    (controlPortIn[2]),
    .readN      (controlPortIn[0]),
    .writeN     (controlPortIn[1]),
    .readActive (readActive),
    .readDone   (readDone),
    .writeDone  (writeDone)
  );

  always_comb begin
    next_portDData      = portDData;
    next_portDDirection = portDDirection;
    next_portEDirection = portEDirection;
    next_portELatch     = portELatch;
    next_analogConfig   = analogConfig;
    next_slaveSelect    = slaveSelect;
    next_irqMask        = irqMask;
    next_ack            = req;
    next_rdData         = 32'h0000_0000;
    if (wrLow && hit(IDX_PORT_D_DATA)) next_portDData = wb_dat_i[7:0];
    if (wrLow && hit(IDX_PORT_D_DIRECTION)) next_portDDirection = wb_dat_i[7:0];
    if (wrLow && hit(IDX_PORT_E_DIRSC)) begin
      next_portEDirection = wb_dat_i[2:0];
      next_slaveSelect    = wb_dat_i[BIT_SLAVE_SELECT];
    end
    if (wrLow && hit(IDX_CONTROL_PORT)) next_portELatch = wb_dat_i[2:0];
    if (wrLow && hit(IDX_ANALOG_CONFIG)) next_analogConfig = wb_dat_i[2:0];
    if (wrLow && hit(IDX_IRQ_MASK)) next_irqMask = wb_dat_i[IRQ_BITS-1:0];
    // external write latches the pins
    if (writeDone) next_portDData = portDIn;
    if (rdReq) begin
      if (hit(IDX_PORT_D_DATA)) begin
        // in slave mode the processor sees the pins latched by the external write
        next_rdData[7:0] = slaveSelect ? portDData : portDIn;
      end else if (hit(IDX_PORT_D_DIRECTION)) begin
        next_rdData[7:0] = portDDirection;
      end else if (hit(IDX_PORT_E_DIRSC)) begin
        next_rdData[7:0] = {inputFull, outputFull, overrun, slaveSelect,
                            1'b0, portEDirection};
      end else if (hit(IDX_CONTROL_PORT)) begin
        next_rdData[2:0] = controlRead;
      end else if (hit(IDX_ANALOG_CONFIG)) begin
        next_rdData[2:0] = analogConfig;
      end else if (hit(IDX_IRQ_STATUS)) begin
        next_rdData[IRQ_BITS-1:0] = irqStatus;
      end else if (hit(IDX_IRQ_MASK)) begin
        next_rdData[IRQ_BITS-1:0] = irqMask;
      end
    end
  end

  // flags: the set wins over the clear; for output-full the set is the processor write and the clear is the external read
  always_comb begin
    next_inputFull  = inputFull;
    next_outputFull = outputFull;
    next_overrun    = overrun;
    next_irqStatus  = irqStatus;
    if (rdReq && hit(IDX_PORT_D_DATA)) next_inputFull = 1'b0;
    if (writeDone) next_inputFull = 1'b1;
    if (readDone) next_outputFull = 1'b0;
    if (wrLow && hit(IDX_PORT_D_DATA) && slaveSelect) next_outputFull = 1'b1;
    if (wrLow && hit(IDX_PORT_E_DIRSC) && !wb_dat_i[BIT_OVERRUN]) next_overrun = 1'b0;
    if (writeDone && inputFull) next_overrun = 1'b1;
    if (rdReq && hit(IDX_IRQ_STATUS)) next_irqStatus = '0;
    if (writeDone) next_irqStatus[IRQ_WRITE_IN] = 1'b1;
    if (readDone) next_irqStatus[IRQ_READ_OUT] = 1'b1;
    if (writeDone && inputFull) next_irqStatus[IRQ_OVERRUN] = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      portDDirection <= RST_PORT_D_DIRECTION;
      portEDirection <= RST_PORT_E_DIRSC[2:0];
      slaveSelect    <= RST_PORT_E_DIRSC[BIT_SLAVE_SELECT];
      analogConfig   <= RST_ANALOG_CONFIG;
      portELatch     <= 3'h0;
      inputFull      <= 1'b0;
      outputFull     <= 1'b0;
      overrun        <= 1'b0;
      irqStatus      <= '0;
      irqMask        <= '0;
      ack            <= 1'b0;
      rdData         <= 32'h0000_0000;
    end else begin
      portDDirection <= next_portDDirection;
      portEDirection <= next_portEDirection;
      slaveSelect    <= next_slaveSelect;
      analogConfig   <= next_analogConfig;
      portELatch     <= next_portELatch;
      inputFull      <= next_inputFull;
      outputFull     <= next_outputFull;
      overrun        <= next_overrun;
      irqStatus      <= next_irqStatus;
      irqMask        <= next_irqMask;
      ack            <= next_ack;
      rdData         <= next_rdData;
    end
  end

  // data latch keeps its value through reset
  always_ff @(posedge core_clk) begin
    portDData <= next_portDData;
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdData;
  assign irq      = |(irqStatus & irqMask);
  assign portDOut = portDData;
  // slave mode drives the latch only during a selected external read, otherwise releases all pins; outside slave mode the direction bits
  assign portDOeN = slaveSelect ? {8{!readActive}} : portDDirection;
  assign controlPortOut = portELatch;
  // direction bits still apply while pins are analog
  assign controlPortOeN = portEDirection;

  property p_write_sets_full;
    @(posedge core_clk) disable iff (reset) writeDone |=> inputFull;
  endproperty
  a_write_sets_full: assert property (p_write_sets_full) else $error("input full not set");

  property p_overrun;
    @(posedge core_clk) disable iff (reset) (writeDone && inputFull) |=> overrun;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_obf_clear;
    @(posedge core_clk) disable iff (reset)
      (readDone && !(wrLow && hit(IDX_PORT_D_DATA))) |=> !outputFull;
  endproperty
  a_obf_clear: assert property (p_obf_clear) else $error("output full not cleared");

  property p_drive_read;
    @(posedge core_clk) disable iff (reset) readActive |-> (portDOeN == 8'h00);
  endproperty
  a_drive_read: assert property (p_drive_read) else $error("data not driven on read");

  property p_latch;
    @(posedge core_clk) disable iff (reset) writeDone |=> (portDData == $past(portDIn));
  endproperty
  a_latch: assert property (p_latch) else $error("pins not latched");

  property p_dir;
    @(posedge core_clk) disable iff (reset) !slaveSelect |-> (portDOeN == portDDirection);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not applied");

  property p_analog_zero;
    @(posedge core_clk) disable iff (reset)
      (rdReq && hit(IDX_CONTROL_PORT)) |=> ((wb_dat_o[2:0] & $past(analogConfig)) == 3'h0);
  endproperty
  a_analog_zero: assert property (p_analog_zero) else $error("analog pin not zero");

  sequence s_rd_data;
    rdReq && hit(IDX_PORT_D_DATA) && !writeDone;
  endsequence
  property p_ibf_clear;
    @(posedge core_clk) disable iff (reset) s_rd_data |=> !inputFull;
  endproperty
  a_ibf_clear: assert property (p_ibf_clear) else $error("input full not cleared");

  property p_reset_val;
    // the sequence form skips the very first edge, where nothing has been reset yet
    @(posedge core_clk) (reset ##1 1'b1) |-> (portDDirection == RST_PORT_D_DIRECTION
      && portEDirection == RST_PORT_E_DIRSC[2:0] && !slaveSelect
      && analogConfig == RST_ANALOG_CONFIG);
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("bad reset value");
endmodule : gpsp_port
`default_nettype wire

//--- gpsp_ext_cpu.sv
`timescale 1ns/1ns
`default_nettype none
module gpsp_ext_cpu (
  // clock
  input  wire logic       core_clk,
  // slave bus
  input  wire logic [7:0] pins,
  output logic      [7:0] busData,
  output logic      [2:0] ctlN
);
  logic [7:0] lastVal = 8'h00;
  logic       drive   = 1'b0;
  initial ctlN = 3'h7;
  // released lines show the inverse, so a stale value cannot pass
  assign busData = drive ? lastVal : ~lastVal;
  task automatic ext_write(input logic [7:0] d);
    @(posedge core_clk);
    lastVal <= d;
    drive <= 1'b1;
    ctlN <= 3'h1;
    repeat (2) @(posedge core_clk);
    ctlN <= 3'h3;  // data held while the write strobe rises
    @(posedge core_clk);
    drive <= 1'b0;
    ctlN <= 3'h7;
    @(posedge core_clk);
  endtask : ext_write
  task automatic ext_read(output logic [7:0] q);
    @(posedge core_clk);
    ctlN <= 3'h2;
    repeat (3) @(posedge core_clk);
    q = pins;
    ctlN <= 3'h7;
    @(posedge core_clk);
  endtask : ext_read
endmodule : gpsp_ext_cpu
`default_nettype wire

//--- tb_port_d_data_control_port_slave_port_io.sv
`timescale 1ns/1ns
`default_nettype none
module tb_port_d_data_control_port_slave_port_io;
  import gpsp_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset    = 1'b1;
  logic        cyc      = 1'b0;
  logic        stb      = 1'b0;
  logic        we       = 1'b0;
  logic [9:0]  adr      = 10'h000;
  logic [31:0] wdat     = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        irq;
  logic [7:0]  dOut;
  logic [7:0]  dOeN;
  logic [7:0]  mdl;
  logic [7:0]  pins;
  logic [7:0]  q;
  logic [2:0]  cOut;
  logic [2:0]  cOeN;
  logic [2:0]  ctlN;
  int          numErrors = 0;
  int          nCompared = 0;
  int          cycles    = 0;
  assign pins = (dOut & ~dOeN) | (mdl & dOeN);
  gpsp_port dut_u (
    .core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .portDIn(pins), .portDOut(dOut),
    .portDOeN(dOeN), .controlPortIn(ctlN), .controlPortOut(cOut),
    .controlPortOeN(cOeN), .irq(irq));
  gpsp_ext_cpu host_u (.core_clk(core_clk), .pins(pins), .busData(mdl), .ctlN(ctlN));
  task automatic summarize();
    $display("compared %0d errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic rd(input logic [9:0] a, input logic [7:0] exp, input string what);
    wb(a, 1'b0, 8'h00);
    chk(what, exp, q);
  endtask : rd
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // ceiling well above the roughly 150 cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      numErrors++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    chk("data oe", 8'hff, dOeN);
    chk("ctl oe", 8'h07, {5'h0, cOeN});
    rd(10'h220, 8'hff, "data dir");
    rd(10'h224, 8'h07, "ctrl reg");
    rd(10'h024, 8'h00, "ctl pins analog");
    rd(10'h3fc, 8'h00, "unmapped");
    wb(10'h020, 1'b1, 8'ha5);
    wb(10'h220, 1'b1, 8'h00);
    rd(10'h020, 8'ha5, "pins driven");
    wb(10'h220, 1'b1, 8'h0f);
    chk("data oe", 8'h0f, dOeN);
    wb(10'h220, 1'b1, 8'hff);
    wb(10'h224, 1'b1, 8'hca);
    chk("ctl oe", 8'h02, {5'h0, cOeN});
    wb(10'h024, 1'b1, 8'h05);
    chk("ctl out", 8'h05, {5'h0, cOut});
    rd(10'h224, 8'h02, "ctrl reg");
    wb(10'h224, 1'b1, 8'h07);
    wb(10'h27c, 1'b1, 8'h00);
    rd(10'h024, 8'h07, "ctl pins digital");
    wb(10'h224, 1'b1, 8'h17);
    wb(10'h230, 1'b1, 8'h07);
    host_u.ext_write(8'h3c);
    rd(10'h224, 8'h97, "ctrl reg");
    chk("irq", 8'h01, {7'h0, irq});
    host_u.ext_write(8'hc3);
    rd(10'h224, 8'hb7, "ctrl reg");
    rd(10'h020, 8'hc3, "slave data");
    rd(10'h224, 8'h37, "ctrl reg");
    wb(10'h224, 1'b1, 8'h17);
    rd(10'h224, 8'h17, "ctrl reg");
    rd(10'h030, 8'h05, "status");
    chk("irq", 8'h00, {7'h0, irq});
    wb(10'h230, 1'b1, 8'h00);
    wb(10'h020, 1'b1, 8'h5a);
    rd(10'h224, 8'h57, "ctrl reg");
    host_u.ext_read(q);
    chk("ext read", 8'h5a, q);
    rd(10'h224, 8'h17, "ctrl reg");
    chk("irq masked", 8'h00, {7'h0, irq});
    wb(10'h230, 1'b1, 8'h07);
    chk("irq", 8'h01, {7'h0, irq});
    rd(10'h030, 8'h02, "status");
    chk("irq", 8'h00, {7'h0, irq});
    // a later reset must leave the data latch alone
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    chk("latch kept", 8'h5a, dOut);
    chk("data oe", 8'hff, dOeN);
    chk("ctl oe", 8'h07, {5'h0, cOeN});
    rd(10'h224, 8'h07, "ctrl reg");
    rd(10'h024, 8'h00, "ctl pins analog");
    summarize();
  end
endmodule : tb_port_d_data_control_port_slave_port_io
`default_nettype wire
